// ### vectored_interrupt_arbiter.sv
// Functional notes
// RULE1: software trap ranks above all; default vector ranks below all.
// RULE2: eleven maskable inputs each have a fixed rank and vector slot.
// RULE3: every source but the trap has an enable bit and pending bit.
// RULE4: source event sets its pending bit regardless of any enable.
// RULE5: maskable fires only with enable, global enable, and no trap in service.
// RULE6: triggers checked at instruction start; highest rank wins, rest stay pending.
// RULE7: reset clears pending bits, enable bits and global enable.
// RULE8: already pending bit fires as soon as its enable is set.
// RULE9: acknowledge only at next executed instruction start, after any skip.
// RULE10: acknowledge start clears the global enable.
// RULE11: acknowledge pushes address of the instruction about to execute.
// RULE12: acknowledge loads the program counter with the common service address.
// RULE13: whole acknowledge sequence lasts seven instruction cycles.
// RULE14: global enable writable via processor status word for nesting.
// RULE15: return sets global enable, pops saved address into program counter.
// RULE16: pending valid interrupts after return are taken at once.
// RULE17: pending and enable bits are memory mapped, readable and writable.
// RULE18: software clears the serviced pending bit early in its routine.
// RULE19: vector select yields even low byte E0..FE for winning source.
// RULE20: vector select with nothing active yields the default vector.
// RULE21: trap in-service flag held from acknowledge to return, blocks maskables.
//
// Our own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module vectored_interrupt_arbiter
    import vectored_interrupt_arbiter_pkg::*;
(
    input wire logic aclk, // instruction domain clock
    input wire logic aresetn, // synchronous reset, active low
    // axi4-lite slave
    input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write byte strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    // interrupt sources
    input wire logic [NUM_SRC-1:0] src_event, // one-cycle event per source
    // core sequencer
    input wire logic instr_start, // pulse, start of an instruction
    input wire logic instr_skip, // with instr_start, this one is skipped
    input wire logic [15:0] instr_addr, // address of instruction about to run
    input wire logic trap_exec, // pulse, software trap instruction
    input wire logic vis_exec, // pulse, vector select instruction
    input wire logic return_from_irq_instruction_exec, // pulse, return from interrupt
    input wire logic [15:0] pop_addr, // address popped by the core on return
    input wire logic psw_write, // pulse, status word write
    input wire logic psw_gie, // global enable value in that write
    output logic ack_busy, // acknowledge sequence running
    output logic push_valid, // pulse, push push_addr onto stack
    output logic [15:0] push_addr, // return address to push
    output logic pc_load, // pulse, load pc_value into the counter
    output logic [15:0] pc_value, // new program counter
    output logic vis_valid, // pulse, vis_low is fresh
    output logic [7:0] vis_low, // new low byte of the counter
    output logic global_irq_enable, // global enable
    output logic trap_in_service // software trap being serviced
);

    typedef enum logic {ST_IDLE, ST_ACK} ack_state_t;

    // bus decode, shared by read and write paths
    function automatic reg_sel_t decode(input logic [ADDR_W-1:0] addr);
        case (addr)
            OFS_PENDING: decode = SEL_PENDING;
            OFS_ENABLE: decode = SEL_ENABLE;
            OFS_CONTROL: decode = SEL_CONTROL;
            OFS_VECTOR: decode = SEL_VECTOR;
            default: decode = SEL_NONE;
        endcase
    endfunction : decode

    // priority encoder: trap first, then lowest index, else default
    function automatic logic [7:0] pick_vector(input logic trap, input logic [NUM_SRC-1:0] act);
        logic [7:0] v;
        v = VEC_DEFAULT; // RULE20
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (act[i]) begin
                v = VEC_TABLE[i]; // RULE2 RULE19
            end
        end
        if (trap) begin
            v = VEC_TRAP; // RULE1
        end
        pick_vector = v;
    endfunction : pick_vector

    logic [NUM_SRC-1:0] pending;
    logic [NUM_SRC-1:0] enable;
    logic trap_pending;
    logic [7:0] vector_last;
    ack_state_t state;
    logic [ACK_CNT_W-1:0] ack_cnt;
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    logic [NUM_SRC-1:0] active;
    logic maskable_go;
    logic trap_go;
    logic ack_start;
    logic do_write;
    reg_sel_t wsel;

    // active sources and trigger qualification
    assign active = pending & enable; // RULE3 RULE8
    assign maskable_go = global_irq_enable && !trap_in_service && (|active); // RULE5 RULE21
    assign trap_go = trap_pending && !trap_in_service;
    // taken only on a normally executed instruction, never a skipped one
    assign ack_start = (state == ST_IDLE) && instr_start && !instr_skip
                       && (maskable_go || trap_go); // RULE6 RULE9 RULE16
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign wsel = decode(aw_addr);

    // write address channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end else if (!aw_held && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
        end
    end

    // write data channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_wready <= 1'b0;
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (do_write) begin
            w_held <= 1'b0;
        end else if (!w_held && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
        end
    end

    // write response, one cycle after both halves are held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // read channel; data latched at the address handshake
    // rdata cleared first so unused upper bits always read zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rdata <= '0;
            case (decode(s_axi_araddr))
                SEL_PENDING: s_axi_rdata[NUM_SRC-1:0] <= pending; // RULE17
                SEL_ENABLE: s_axi_rdata[NUM_SRC-1:0] <= enable; // RULE17
                SEL_CONTROL: begin
                    s_axi_rdata[CTL_GIE_BIT] <= global_irq_enable;
                    s_axi_rdata[CTL_TRAP_PEND_BIT] <= trap_pending;
                    s_axi_rdata[CTL_TRAP_SERV_BIT] <= trap_in_service;
                    s_axi_rdata[CTL_ACK_BUSY_BIT] <= ack_busy;
                end
                SEL_VECTOR: s_axi_rdata[7:0] <= vector_last;
                default: s_axi_rresp <= RESP_SLVERR;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end

    // pending flags: a source event wins over a software clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pending <= PENDING_RST; // RULE7
        end else if (do_write && wsel == SEL_PENDING && w_strb[0] && w_strb[1]) begin
            pending <= w_data[NUM_SRC-1:0] | src_event; // RULE4 RULE17 RULE18
        end else begin
            pending <= pending | src_event; // RULE4
        end
    end

    // individual enables; both low bytes must be strobed since the field spans them
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enable <= ENABLE_RST; // RULE7
        end else if (do_write && wsel == SEL_ENABLE && w_strb[0] && w_strb[1]) begin
            enable <= w_data[NUM_SRC-1:0]; // RULE17
        end
    end

    // global enable: acknowledge clear outranks return, status word and bus
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            global_irq_enable <= GIE_RST; // RULE7
        end else if (ack_start) begin
            global_irq_enable <= 1'b0; // RULE10
        end else if (return_from_irq_instruction_exec) begin
            global_irq_enable <= 1'b1; // RULE15
        end else if (psw_write) begin
            global_irq_enable <= psw_gie; // RULE14
        end else if (do_write && wsel == SEL_CONTROL && w_strb[0]) begin
            global_irq_enable <= w_data[CTL_GIE_BIT]; // RULE14
        end
    end

    // software trap pending: set by the trap, consumed when vector select picks it
    // a trap raised in the same cycle as vector select stays pending, set wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trap_pending <= 1'b0;
        end else if (trap_exec) begin
            trap_pending <= 1'b1;
        end else if (vis_exec) begin
            trap_pending <= 1'b0;
        end
    end

    // trap in service from its acknowledge to the next return
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trap_in_service <= 1'b0;
        end else if (ack_start && trap_go) begin
            trap_in_service <= 1'b1; // RULE21
        end else if (return_from_irq_instruction_exec) begin
            trap_in_service <= 1'b0; // RULE21
        end
    end

    // acknowledge sequencer; the core must hold off instructions while busy
    // one counter for the whole sequence keeps its length in one constant
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_IDLE;
            ack_cnt <= '0;
            ack_busy <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (ack_start) begin
                        state <= ST_ACK;
                        ack_cnt <= ACK_CNT_W'(ACK_CLKS - 1); // RULE13
                        ack_busy <= 1'b1;
                    end
                end
                ST_ACK: begin
                    if (ack_cnt == '0) begin
                        state <= ST_IDLE;
                        ack_busy <= 1'b0;
                    end else begin
                        ack_cnt <= ack_cnt - 1'b1; // RULE13
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    ack_busy <= 1'b0;
                end
            endcase
        end
    end

    // return address push at the start of the sequence
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            push_valid <= 1'b0;
            push_addr <= '0;
        end else begin
            push_valid <= ack_start;
            if (ack_start) begin
                push_addr <= instr_addr; // RULE11
            end
        end
    end

    // counter load: service address at the last sequence cycle, popped address on return
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pc_load <= 1'b0;
            pc_value <= '0;
        end else if (state == ST_ACK && ack_cnt == '0) begin
            pc_load <= 1'b1;
            pc_value <= SERVICE_ADDR; // RULE12
        end else if (return_from_irq_instruction_exec) begin
            pc_load <= 1'b1;
            pc_value <= pop_addr; // RULE15
        end else begin
            pc_load <= 1'b0;
        end
    end

    // vector select result, sampled at its first cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            vis_valid <= 1'b0;
            vis_low <= VECTOR_RST;
            vector_last <= VECTOR_RST;
        end else begin
            vis_valid <= vis_exec;
            if (vis_exec) begin
                vis_low <= pick_vector(trap_pending, active); // RULE19
                vector_last <= pick_vector(trap_pending, active);
            end
        end
    end

endmodule : vectored_interrupt_arbiter

// ### vectored_interrupt_arbiter_pkg.sv
package vectored_interrupt_arbiter_pkg;

    // source count and bus geometry
    localparam int NUM_SRC = 11;
    localparam int ADDR_W = 4;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_PENDING = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_ENABLE = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_VECTOR = 4'hC;

    // control register field positions
    localparam int CTL_GIE_BIT = 0;
    localparam int CTL_TRAP_PEND_BIT = 1;
    localparam int CTL_TRAP_SERV_BIT = 2;
    localparam int CTL_ACK_BUSY_BIT = 3;

    // reset values
    localparam logic [NUM_SRC-1:0] PENDING_RST = 11'h000;
    localparam logic [NUM_SRC-1:0] ENABLE_RST = 11'h000;
    localparam logic GIE_RST = 1'b0;
    localparam logic [7:0] VECTOR_RST = 8'hE0;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // service address and vector low bytes, index 0 ranks highest
    localparam logic [15:0] SERVICE_ADDR = 16'h00FF;
    localparam logic [7:0] VEC_TRAP = 8'hFE;
    localparam logic [7:0] VEC_DEFAULT = 8'hE0;
    localparam logic [7:0] VEC_TABLE [NUM_SRC] = '{
        8'hFA, 8'hF8, 8'hF6, 8'hF4, 8'hF2, 8'hEE,
        8'hEA, 8'hE8, 8'hE6, 8'hE4, 8'hE2
    };

    // timing: clock 100 ns, instruction cycle 1000 ns, acknowledge 7 instruction cycles
    localparam int CLK_PERIOD_NS = 100;
    localparam int INSTR_CYCLE_NS = 1000;
    localparam int ACK_INSTR_CYCLES = 7;
    localparam int CLKS_PER_INSTR = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACK_CLKS = ACK_INSTR_CYCLES * CLKS_PER_INSTR;
    localparam int ACK_CNT_W = 8;

    // register selection
    typedef enum logic [2:0] {
        SEL_PENDING,
        SEL_ENABLE,
        SEL_CONTROL,
        SEL_VECTOR,
        SEL_NONE
    } reg_sel_t;

endpackage : vectored_interrupt_arbiter_pkg

// ### core_seq_model.sv
`timescale 1ns/1ps
// core sequencer: one instruction every ten clocks and a small return stack
module core_seq_model (
    input wire logic aclk, // clock
    input wire logic aresetn, // sync reset, active low
    input wire logic skip_req, // mark issued instructions as skipped
    input wire logic ack_busy, // core stalls while acknowledge runs
    input wire logic push_valid, // push request
    input wire logic [15:0] push_addr, // address to push
    input wire logic return_from_irq_instruction_exec, // pop on return
    output logic instr_start, // instruction start pulse
    output logic instr_skip, // skip qualifier
    output logic [15:0] instr_addr, // address about to run
    output logic [15:0] pop_addr // top of stack
);
    logic [3:0] cnt;
    logic [2:0] sp;
    logic [15:0] stk [4];
    // pacing halts during acknowledge, as a real core executes nothing then
    always_ff @(posedge aclk) begin
        if (!aresetn || ack_busy) begin
            cnt <= 4'h0;
            instr_start <= 1'b0;
        end else begin
            cnt <= (cnt == 4'h9) ? 4'h0 : cnt + 4'h1;
            instr_start <= (cnt == 4'h9);
        end
        instr_skip <= skip_req;
    end
    // address stays put from its start pulse until the next one
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            instr_addr <= 16'h0100;
        end else if (cnt == 4'h9 && !ack_busy) begin
            instr_addr <= instr_addr + 16'h0001;
        end
    end
    // stack of four; deeper nesting is not exercised
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sp <= 3'h0;
        end else if (push_valid) begin
            stk[sp[1:0]] <= push_addr;
            sp <= sp + 3'h1;
        end else if (return_from_irq_instruction_exec && sp != 3'h0) begin
            sp <= sp - 3'h1;
        end
    end
    assign pop_addr = (sp == 3'h0) ? 16'h0000 : stk[sp[1:0] - 2'h1];
endmodule : core_seq_model

// ### vectored_interrupt_arbiter_sva.sv
`timescale 1ns/1ps
// acknowledge, return and vector select seen at the top ports
module vectored_interrupt_arbiter_sva
    import vectored_interrupt_arbiter_pkg::*;
(
    input wire logic aclk, // clock
    input wire logic aresetn, // reset
    input wire logic instr_start, // start
    input wire logic instr_skip, // skip
    input wire logic [15:0] instr_addr, // address
    input wire logic return_from_irq_instruction_exec, // return
    input wire logic [15:0] pop_addr, // popped
    input wire logic psw_write, // status write
    input wire logic psw_gie, // status value
    input wire logic vis_exec, // vector select
    input wire logic ack_busy, // busy
    input wire logic push_valid, // push
    input wire logic [15:0] push_addr, // pushed
    input wire logic pc_load, // load
    input wire logic [15:0] pc_value, // pc
    input wire logic vis_valid, // vector fresh
    input wire logic [7:0] vis_low, // vector byte
    input wire logic global_irq_enable, // gie
    input wire logic trap_in_service // trap busy
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // acknowledge start and end, seventy clocks apart
    sequence s_ack_start;
        $rose(ack_busy);
    endsequence
    sequence s_ack_end;
        pc_load && pc_value == SERVICE_ADDR && !ack_busy;
    endsequence
    property p_ack_take;
        s_ack_start |-> $past(instr_start) && !$past(instr_skip);
    endproperty
    a_ack_take: assert property (p_ack_take) else $error("ack without start");
    property p_ack_push;
        s_ack_start |-> push_valid && push_addr == $past(instr_addr) && !global_irq_enable;
    endproperty
    a_ack_push: assert property (p_ack_push) else $error("ack push wrong");
    property p_ack_len;
        s_ack_start |-> ##70 s_ack_end;
    endproperty
    a_ack_len: assert property (p_ack_len) else $error("ack end wrong");
    // return_from_irq_instruction coinciding with a start may lose to the acknowledge, so it is excluded
    property p_return_from_irq_instruction;
        return_from_irq_instruction_exec && !ack_busy && !instr_start |=> global_irq_enable && !trap_in_service
            && pc_load && pc_value == $past(pop_addr);
    endproperty
    a_return_from_irq_instruction: assert property (p_return_from_irq_instruction) else $error("return wrong");
    property p_psw;
        psw_write && !ack_busy && !instr_start && !return_from_irq_instruction_exec |=> global_irq_enable == $past(psw_gie);
    endproperty
    a_psw: assert property (p_psw) else $error("status write lost");
    property p_trap_block;
        trap_in_service && instr_start |=> !$rose(ack_busy);
    endproperty
    a_trap_block: assert property (p_trap_block) else $error("ack during trap");
    property p_trap_hold;
        $fell(trap_in_service) |-> $past(return_from_irq_instruction_exec) || !$past(aresetn);
    endproperty
    a_trap_hold: assert property (p_trap_hold) else $error("trap flag dropped");
    property p_vis;
        vis_exec |=> vis_valid && !vis_low[0] && vis_low >= 8'hE0;
    endproperty
    a_vis: assert property (p_vis) else $error("vector byte wrong");
endmodule : vectored_interrupt_arbiter_sva
bind vectored_interrupt_arbiter vectored_interrupt_arbiter_sva chk (.aclk, .aresetn,
    .instr_start, .instr_skip, .instr_addr, .return_from_irq_instruction_exec, .pop_addr, .psw_write, .psw_gie,
    .vis_exec, .ack_busy, .push_valid, .push_addr, .pc_load, .pc_value, .vis_valid, .vis_low,
    .global_irq_enable, .trap_in_service);

// ### vectored_interrupt_arbiter_tb.sv
`timescale 1ns/1ps
module vectored_interrupt_arbiter_tb
    import vectored_interrupt_arbiter_pkg::*;
;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, skip_req;
    logic instr_start, instr_skip, psw_gie, ack_busy, push_valid, pc_load, vis_valid;
    logic global_irq_enable, trap_in_service, aw_done, w_done;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb, cmd;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic [NUM_SRC-1:0] src_event, m;
    logic [15:0] instr_addr, pop_addr, push_addr, pc_value, exp_pop;
    logic [7:0] vis_low;
    int bad_count, n_tests;
    // cmd bits: trap, vector select, return, status word write
    vectored_interrupt_arbiter DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .src_event, .instr_start, .instr_skip, .instr_addr,
        .trap_exec(cmd[0]), .vis_exec(cmd[1]), .return_from_irq_instruction_exec(cmd[2]), .pop_addr, .psw_write(cmd[3]),
        .psw_gie, .ack_busy, .push_valid, .push_addr, .pc_load, .pc_value, .vis_valid, .vis_low,
        .global_irq_enable, .trap_in_service);
    core_seq_model core (.aclk, .aresetn, .skip_req, .ack_busy, .push_valid, .push_addr,
        .return_from_irq_instruction_exec(cmd[2]), .instr_start, .instr_skip, .instr_addr, .pop_addr);
    // 100 ns clock
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
        end
    endtask : chk
    task final_report();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report
    // address and data offered together, each dropped once taken
    task axi_write(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        {aw_done, w_done} = 2'h0;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) begin
                s_axi_awvalid <= 1'b0;
                aw_done = 1'b1;
            end
            if (s_axi_wready === 1'b1) begin
                s_axi_wvalid <= 1'b0;
                w_done = 1'b1;
            end
        end
        while (s_axi_bvalid !== 1'b1) @(posedge aclk);
        rr = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axi_write
    task axi_read(input logic [ADDR_W-1:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        @(posedge aclk);
        while (s_axi_arready !== 1'b1) @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1) @(posedge aclk);
        {rd, rr} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
    endtask : axi_read
    // one-cycle command pulse; stack top noted for the return check
    task strobe(input logic [3:0] c, input logic g);
        @(posedge aclk);
        {cmd, psw_gie} <= {c, g};
        exp_pop = pop_addr;
        @(posedge aclk);
        cmd <= 4'h0;
        #1;
    endtask : strobe
    task wait_ack(input logic v);
        for (int i = 0; i < 100 && ack_busy !== v; i++) @(posedge aclk);
        #1;
        chk("ack_busy", v, ack_busy);
    endtask : wait_ack
    task vector_select_instruction(input logic [7:0] e);
        strobe(4'h2, 1'b0);
        chk("vis_low", {1'b1, e}, {vis_valid, vis_low});
    endtask : vector_select_instruction
    task return_from_irq_instruction();
        strobe(4'h4, 1'b0);
        chk("return", {2'h2, exp_pop}, {global_irq_enable, trap_in_service, pc_value});
    endtask : return_from_irq_instruction
    task t_reset();
        chk("gie", 1'b0, global_irq_enable);
        for (int i = 0; i < 3; i++) begin
            axi_read(4'(4 * i));
            chk("reg", 32'h0, rd);
        end
        axi_read(OFS_VECTOR);
        chk("vector", {24'h0, VECTOR_RST}, rd);
        axi_read(4'h2);
        chk("unmapped", RESP_SLVERR, rr);
        axi_write(4'h2, 32'h1);
        chk("bresp", RESP_SLVERR, rr);
    endtask : t_reset
    task t_masked();
        strobe(4'h8, 1'b1);
        chk("gie", 1'b1, global_irq_enable);
        @(posedge aclk);
        src_event <= 11'h008;
        @(posedge aclk);
        src_event <= 11'h000;
        repeat (30) @(posedge aclk);
        chk("ack_busy", 1'b0, ack_busy);
        axi_read(OFS_PENDING);
        chk("pending", 32'h8, rd);
        skip_req <= 1'b1;
        axi_write(OFS_ENABLE, 32'h8);
        chk("bresp", RESP_OKAY, rr);
        repeat (30) @(posedge aclk);
        chk("ack_busy", 1'b0, ack_busy);
        skip_req <= 1'b0;
        wait_ack(1'b1);
        chk("ack", {1'b0, instr_addr}, {global_irq_enable, push_addr});
        wait_ack(1'b0);
        chk("pc_value", SERVICE_ADDR, pc_value);
        vector_select_instruction(VEC_TABLE[3]);
        axi_write(OFS_PENDING, 32'h0);
        return_from_irq_instruction();
    endtask : t_masked
    task t_priority();
        strobe(4'h8, 1'b0);
        axi_write(OFS_ENABLE, 32'h7FF);
        @(posedge aclk);
        src_event <= 11'h7FF;
        @(posedge aclk);
        src_event <= 11'h000;
        m = 11'h7FF;
        for (int i = 0; i < NUM_SRC; i++) begin
            vector_select_instruction(VEC_TABLE[i]);
            m[i] = 1'b0;
            axi_write(OFS_PENDING, {21'h0, m});
            axi_read(OFS_PENDING);
            chk("pending", {21'h0, m}, rd);
        end
        vector_select_instruction(VEC_DEFAULT);
    endtask : t_priority
    task t_trap();
        @(posedge aclk);
        src_event <= 11'h020;
        @(posedge aclk);
        src_event <= 11'h000;
        strobe(4'h1, 1'b0);
        wait_ack(1'b1);
        chk("trap_in_service", 1'b1, trap_in_service);
        wait_ack(1'b0);
        vector_select_instruction(VEC_TRAP);
        strobe(4'h8, 1'b1);
        repeat (30) @(posedge aclk);
        chk("ack_busy", 1'b0, ack_busy);
        return_from_irq_instruction();
        wait_ack(1'b1);
        chk("push_addr", instr_addr, push_addr);
        wait_ack(1'b0);
    endtask : t_trap
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, cmd, psw_gie, skip_req, src_event} = '0;
        s_axi_wstrb = 4'hF;
        {bad_count, n_tests} = 64'h0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_masked();
        t_priority();
        t_trap();
        final_report();
    end
    // the sequence needs well under a thousand clocks; forty thousand means a hang
    initial begin
        #(100 * 40000);
        bad_count++;
        final_report();
    end
endmodule : vectored_interrupt_arbiter_tb
